// File: verilog/current_output_code_and_diag.sv
`timescale 1ns/10ps
module current_output_code_and_diag
  import current_output_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic paramWrEn,
  input wire logic [7:0] paramRecordNumber,
  input wire logic [7:0] paramByteOffset,
  input wire logic [7:0] paramWrData,
  output logic paramWrAck,
  output logic paramWrReject,
  input wire logic [15:0] outCode0,
  input wire logic [15:0] outCode1,
  output logic [14:0] currentUa0,
  output logic [14:0] currentUa1,
  output logic channelOn0,
  output logic channelOn1,
  input wire logic wireBreakPin0,
  input wire logic wireBreakPin1,
  input wire logic auxSupplyMissingPin,
  input wire logic moduleFailPin,
  input wire logic internalCommFailPin,
  output logic channelFaultLed0,
  output logic channelFaultLed1,
  output logic groupFaultLed,
  input wire logic diagRdEn,
  input wire logic [1:0] diagAccessKind,
  input wire logic [15:0] diagSelector,
  input wire logic [4:0] diagByteOffset,
  output logic diagRdValid,
  output logic [7:0] diagRdData,
  output logic diagRdReject
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic fnValid(input logic [7:0] fn);
    fnValid = (fn == FN_ZERO_WIDE) || (fn == FN_ZERO_NARROW) ||
              (fn == FN_LIVE_WIDE) || (fn == FN_LIVE_NARROW) || (fn == FN_OFF);
  endfunction

  function automatic logic [14:0] computeUa(input logic [7:0] fn, input logic [15:0] code);
    logic signed [33:0] d;
    logic signed [33:0] lo;
    logic signed [33:0] hi;
    logic signed [33:0] num;
    logic signed [33:0] den;
    logic signed [33:0] base;
    logic signed [33:0] q;
    d = 34'($signed(code));
    lo = 34'sh0;
    hi = 34'sh0;
    num = 34'sh0;
    den = 34'sh1;
    base = 34'sh0;
    case (fn)
      FN_ZERO_WIDE: begin // [RULE3] [RULE23]
        hi = 34'(OVER_WIDE);
        num = 34'(FULL_SCALE_UA);
        den = 34'(NOM_WIDE);
      end
      FN_ZERO_NARROW: begin // [RULE4] [RULE23]
        hi = 34'(OVER_NARROW);
        num = 34'(FULL_SCALE_UA);
        den = 34'(NOM_NARROW);
      end
      FN_LIVE_WIDE: begin // [RULE5]
        lo = 34'(UNDER_WIDE);
        hi = 34'(OVER_WIDE);
        num = 34'(SPAN_UA);
        den = 34'(NOM_WIDE);
        base = 34'(LIVE_ZERO_UA);
      end
      FN_LIVE_NARROW: begin // [RULE6]
        lo = 34'(UNDER_NARROW);
        hi = 34'(OVER_NARROW);
        num = 34'(SPAN_UA);
        den = 34'(NOM_NARROW);
        base = 34'(LIVE_ZERO_UA);
      end
      default: begin
        num = 34'sh0;
      end
    endcase
    if (d < lo) begin
      d = lo;
    end
    if (d > hi) begin
      d = hi;
    end
    q = base + (d * num) / den;
    computeUa = q[14:0];
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  wire [4:0] pinRaw = {internalCommFailPin, moduleFailPin, auxSupplyMissingPin,
                       wireBreakPin1, wireBreakPin0};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinMeta_q <= 5'h00;
      pinSync_q <= 5'h00;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  wire auxMissing = pinSync_q[2];
  wire moduleFail = pinSync_q[3];
  wire commFail = pinSync_q[4];

  // ****************************************************************
  // Parameter writes
  // ****************************************************************
  logic [7:0] wireBreakEnable_q;
  logic [7:0] fnNumber_q [2];
  logic paramWrAck_q;
  logic paramWrReject_q;

  wire wrWireBreak = paramWrEn && (paramRecordNumber == REC_PARAM_BASIC) &&
                     (paramByteOffset == PARAM_WB_OFFSET);
  wire wrFn0 = paramWrEn && (paramRecordNumber == REC_FN_CH0) &&
               (paramByteOffset == PARAM_FN_OFFSET);
  wire wrFn1 = paramWrEn && (paramRecordNumber == REC_FN_CH1) &&
               (paramByteOffset == PARAM_FN_OFFSET);
  wire wrHit = wrWireBreak || wrFn0 || wrFn1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wireBreakEnable_q <= WB_ENABLE_RESET;
      fnNumber_q[0] <= FN_RESET;
      fnNumber_q[1] <= FN_RESET;
      paramWrAck_q <= 1'b0;
      paramWrReject_q <= 1'b0;
    end else begin
      if (wrWireBreak) begin
        wireBreakEnable_q <= {6'h00, paramWrData[1:0]}; // [RULE1]
      end
      if (wrFn0) begin
        fnNumber_q[0] <= paramWrData;
      end
      if (wrFn1) begin
        fnNumber_q[1] <= paramWrData;
      end
      paramWrAck_q <= wrHit;
      paramWrReject_q <= paramWrEn && !wrHit;
    end
  end

  assign paramWrAck = paramWrAck_q;
  assign paramWrReject = paramWrReject_q;

  // ****************************************************************
  // Channel scaling and per-channel faults
  // ****************************************************************
  wire [15:0] codeIn [2];
  logic [14:0] currentUa_q [2];
  logic chanOn_q [2];
  logic [7:0] detail [2];
  logic paramFault [2];
  assign codeIn[0] = outCode0;
  assign codeIn[1] = outCode1;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wire valid = fnValid(fnNumber_q[ch]);
    wire active = valid && (fnNumber_q[ch] != FN_OFF); // [RULE2]
    wire [14:0] currentD = active ? computeUa(fnNumber_q[ch], codeIn[ch]) : 15'h0000;
    wire wireFault = wireBreakEnable_q[ch] && pinSync_q[ch] && active; // [RULE1] [RULE8]
    assign paramFault[ch] = !valid; // [RULE24]

    always_comb begin
      detail[ch] = 8'h00;
      detail[ch][DETAIL_PARAM] = paramFault[ch]; // [RULE19]
      detail[ch][DETAIL_WIRE] = wireFault; // [RULE19]
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        currentUa_q[ch] <= 15'h0000;
        chanOn_q[ch] <= 1'b0;
      end else begin
        currentUa_q[ch] <= currentD;
        chanOn_q[ch] <= active;
      end
    end

    a_fn_off_drive: assert property (@(posedge sys_clk) disable iff (rst)
      (fnNumber_q[ch] == FN_OFF) |=> (currentUa_q[ch] == 15'h0000) && !chanOn_q[ch]) // [RULE2]
      else $error("Switched-off channel still drives current");
    a_wire_gate: assert property (@(posedge sys_clk) disable iff (rst)
      !wireBreakEnable_q[ch] |-> !detail[ch][DETAIL_WIRE]) // [RULE1]
      else $error("Wire break reported while detection disabled");
  end

  assign currentUa0 = currentUa_q[0];
  assign currentUa1 = currentUa_q[1];
  assign channelOn0 = chanOn_q[0];
  assign channelOn1 = chanOn_q[1];

  a_scale_full: assert property (@(posedge sys_clk) disable iff (rst)
    (fnNumber_q[0] == FN_ZERO_WIDE) && (outCode0 == 16'h6c00) |=>
    (currentUa0 == 15'(FULL_SCALE_UA))) // [RULE3]
    else $error("Full scale code does not give 20 mA");
  a_clamp_neg: assert property (@(posedge sys_clk) disable iff (rst)
    (fnNumber_q[0] == FN_ZERO_NARROW) && outCode0[15] |=> (currentUa0 == 15'h0000)) // [RULE23]
    else $error("Negative code not clamped to 0 mA");
  a_over_narrow: assert property (@(posedge sys_clk) disable iff (rst)
    (fnNumber_q[1] == FN_ZERO_NARROW) && (outCode1 == 16'h5000) |=>
    (currentUa1 == 15'h61a8)) // [RULE4]
    else $error("Narrow overrange code does not give 25 mA");
  a_live_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (fnNumber_q[1] == FN_LIVE_WIDE) && (outCode1 == 16'h0000) |=>
    (currentUa1 == 15'(LIVE_ZERO_UA))) // [RULE5]
    else $error("Live zero code does not give 4 mA");
  a_under_narrow: assert property (@(posedge sys_clk) disable iff (rst)
    (fnNumber_q[0] == FN_LIVE_NARROW) && (outCode0 == 16'hf000) |=>
    (currentUa0 == 15'h0000)) // [RULE6]
    else $error("Narrow underrange code does not give 0 mA");

  // ****************************************************************
  // Diagnostic bytes
  // ****************************************************************
  wire anyWire = detail[0][DETAIL_WIRE] || detail[1][DETAIL_WIRE];
  wire anyParam = paramFault[0] || paramFault[1];
  wire [7:0] groupErrors = {6'h00, |detail[1], |detail[0]}; // [RULE20]
  logic [7:0] summary;
  logic [7:0] intFlags;

  always_comb begin
    intFlags = 8'h00;
    intFlags[INTFLAG_COMM] = commFail;
    summary = 8'h00;
    summary[SUM_MODULE_FAIL] = moduleFail; // [RULE12]
    summary[SUM_INTERNAL] = |intFlags; // [RULE12]
    summary[SUM_EXTERNAL] = anyWire || auxMissing; // [RULE12]
    summary[SUM_CHANNEL] = |groupErrors; // [RULE12]
    summary[SUM_AUX_MISSING] = auxMissing; // [RULE13]
    summary[SUM_PARAM] = anyParam; // [RULE14] [RULE8]
  end

  a_param_flag: assert property (@(posedge sys_clk) disable iff (rst)
    !fnValid(fnNumber_q[1]) |-> summary[SUM_PARAM] && detail[1][DETAIL_PARAM]) // [RULE24]
    else $error("Unknown function number not flagged");
  a_group_bit: assert property (@(posedge sys_clk) disable iff (rst)
    (detail[0] != 8'h00) |-> groupErrors[0] && summary[SUM_CHANNEL]) // [RULE20]
    else $error("Channel fault missing from group byte");

  // ****************************************************************
  // Microsecond ticker and event stamp
  // ****************************************************************
  logic [6:0] prescale_q;
  logic [31:0] usTicker_q;
  logic [31:0] stamp_q;
  logic [39:0] diagSnap_q;
  wire [39:0] diagLive = {summary, intFlags, groupErrors, detail[0], detail[1]};
  wire tickWrap = (prescale_q == TICK_CYCLES - 7'h01);
  wire diagEvent = (diagLive != diagSnap_q);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prescale_q <= PRESCALE_RESET;
      usTicker_q <= TICKER_RESET;
      stamp_q <= TICKER_RESET;
      diagSnap_q <= 40'h0000000000;
    end else begin
      prescale_q <= tickWrap ? PRESCALE_RESET : prescale_q + 7'h01;
      if (tickWrap) begin
        usTicker_q <= usTicker_q + 32'h00000001; // [RULE21]
      end
      if (diagEvent) begin
        stamp_q <= usTicker_q; // [RULE22]
      end
      diagSnap_q <= diagLive;
    end
  end

  a_ticker_step: assert property (@(posedge sys_clk) disable iff (rst)
    tickWrap |=> (usTicker_q == $past(usTicker_q) + 32'h00000001)) // [RULE21]
    else $error("Microsecond ticker did not advance");
  a_ticker_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !tickWrap |=> $stable(usTicker_q)) // [RULE21]
    else $error("Microsecond ticker moved between ticks");
  a_stamp_capture: assert property (@(posedge sys_clk) disable iff (rst)
    diagEvent |=> (stamp_q == $past(usTicker_q))) // [RULE22]
    else $error("Timestamp not captured at diagnostic event");

  // ****************************************************************
  // Indicators
  // ****************************************************************
  logic [1:0] chanLed_q;
  logic groupLed_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chanLed_q <= 2'h0;
      groupLed_q <= 1'b0;
    end else begin
      chanLed_q <= groupErrors[1:0]; // [RULE7]
      groupLed_q <= |summary;
    end
  end

  assign channelFaultLed0 = chanLed_q[0];
  assign channelFaultLed1 = chanLed_q[1];
  assign groupFaultLed = groupLed_q;

  // ****************************************************************
  // Diagnostic read access
  // ****************************************************************
  logic [7:0] diagBytes [20];
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      diagBytes[i] = 8'h00; // [RULE18]
    end
    diagBytes[0] = summary;
    diagBytes[1] = MODULE_CLASS_INFO; // [RULE15]
    diagBytes[3] = intFlags;
    diagBytes[4] = CHANNEL_KIND; // [RULE17]
    diagBytes[5] = BITS_PER_CHANNEL; // [RULE16]
    diagBytes[6] = CHANNEL_COUNT; // [RULE17]
    diagBytes[7] = groupErrors;
    diagBytes[8] = detail[0]; // [RULE18]
    diagBytes[9] = detail[1]; // [RULE18]
    diagBytes[16] = stamp_q[31:24];
    diagBytes[17] = stamp_q[23:16];
    diagBytes[18] = stamp_q[15:8];
    diagBytes[19] = stamp_q[7:0];
  end

  wire isRecord = (diagAccessKind == ACC_RECORD);
  wire isCanopen = (diagAccessKind == ACC_CANOPEN);
  wire isEcat = (diagAccessKind == ACC_ETHERCAT) && (diagByteOffset < STAMP_LEN);
  wire selFull = (isRecord && (diagSelector == REC_DIAG_FULL)) ||
                 (isCanopen && (diagSelector == IDX_DIAG_FULL)); // [RULE9] [RULE10]
  wire selShort = (isRecord && (diagSelector == REC_DIAG_SHORT)) ||
                  (isCanopen && (diagSelector == IDX_DIAG_SHORT)); // [RULE9] [RULE10]
  wire ecatIndexOk = (diagSelector[15:8] == 8'h00);
  wire ecatByteSub = isEcat && ecatIndexOk && (diagByteOffset == 5'h00) &&
                     (diagSelector >= SUB_FIRST) && (diagSelector <= SUB_RSVD_LAST); // [RULE11]
  wire ecatStampSub = isEcat && ecatIndexOk && (diagSelector == SUB_STAMP); // [RULE11]
  wire [4:0] ecatIdx = ecatStampSub ? BYTE_STAMP + diagByteOffset :
                       5'(diagSelector[4:0] - SUB_FIRST[4:0]);
  wire linearOk = (selFull && (diagByteOffset < DIAG_FULL_LEN)) ||
                  (selShort && (diagByteOffset < DIAG_SHORT_LEN));
  wire readOk = linearOk || ecatByteSub || ecatStampSub;
  wire [4:0] readIdx = linearOk ? diagByteOffset : ecatIdx;

  logic diagRdValid_q;
  logic diagRdReject_q;
  logic [7:0] diagRdData_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      diagRdValid_q <= 1'b0;
      diagRdReject_q <= 1'b0;
      diagRdData_q <= 8'h00;
    end else begin
      diagRdValid_q <= diagRdEn && readOk;
      diagRdReject_q <= diagRdEn && !readOk;
      if (diagRdEn) begin
        diagRdData_q <= readOk ? diagBytes[readIdx] : 8'h00;
      end
    end
  end

  assign diagRdValid = diagRdValid_q;
  assign diagRdReject = diagRdReject_q;
  assign diagRdData = diagRdData_q;

  a_record_short: assert property (@(posedge sys_clk) disable iff (rst)
    diagRdEn && isRecord && (diagSelector == REC_DIAG_SHORT) &&
    (diagByteOffset >= DIAG_SHORT_LEN) |=> diagRdReject && !diagRdValid) // [RULE9]
    else $error("Short record served beyond its fourth byte");
  a_canopen_kind: assert property (@(posedge sys_clk) disable iff (rst)
    diagRdEn && isCanopen && (diagSelector == IDX_DIAG_FULL) &&
    (diagByteOffset == BYTE_KIND) |=> diagRdValid && (diagRdData == CHANNEL_KIND)) // [RULE10]
    else $error("Channel kind byte wrong over full index");
  a_ecat_first: assert property (@(posedge sys_clk) disable iff (rst)
    diagRdEn && (diagAccessKind == ACC_ETHERCAT) && (diagSelector == SUB_FIRST) &&
    (diagByteOffset == 5'h00) |=> diagRdValid && (diagRdData == $past(summary))) // [RULE11]
    else $error("First subindex does not return the summary byte");

endmodule // current_output_code_and_diag

// File: common/current_output_pkg.sv
// Function
// RULE1 - Wire-break enable bits 0 and 1 per channel
// RULE2 - Function number FFh switches channel off
// RULE3 - Code 31h: 27648 is 20 mA, over 32511
// RULE4 - Code 41h: 16384 is 20 mA, over 20480
// RULE5 - Code 30h: 4 mA plus 16 mA/27648
// RULE6 - Code 40h: 4 mA plus 16 mA/16384
// RULE7 - No interrupt; light channel indicator, record error
// RULE8 - Report parameter errors and enabled wire breaks
// RULE9 - Record 01h full, record 00h first four
// RULE10 - CANopen index 2F01h full, 2F00h four bytes
// RULE11 - EtherCAT index 5005h, subindex 02h first byte
// RULE12 - Summary bits 0..3 failure, internal, external, channel
// RULE13 - Summary bit 4 on missing auxiliary supply
// RULE14 - Summary bit 7 on parameterization error
// RULE15 - Module information byte reads 15h analog class
// RULE16 - Eight diagnostic bits per channel reported
// RULE17 - Two channels, channel kind 73h reported
// RULE18 - Two channel error bytes, six reserved zero
// RULE19 - Channel detail bit 0 parameter, bit 4 break
// RULE20 - Group byte bit per faulty channel
// RULE21 - Free running 32-bit microsecond counter wraps
// RULE22 - Counter value stored at each diagnostic event
// RULE23 - Negative codes clamp to 0 mA in 0-20 ranges
// RULE24 - Unknown function number is a parameterization error
package current_output_pkg;

  // ****************************************************************
  // Function numbers and parameter defaults
  // ****************************************************************
  localparam logic [7:0] FN_ZERO_WIDE = 8'h31;
  localparam logic [7:0] FN_ZERO_NARROW = 8'h41;
  localparam logic [7:0] FN_LIVE_WIDE = 8'h30;
  localparam logic [7:0] FN_LIVE_NARROW = 8'h40;
  localparam logic [7:0] FN_OFF = 8'hff;
  localparam logic [7:0] FN_RESET = 8'h31;
  localparam logic [7:0] WB_ENABLE_RESET = 8'h00;

  // ****************************************************************
  // Record numbers, object indices and subindices
  // ****************************************************************
  localparam logic [7:0] REC_PARAM_BASIC = 8'h00;
  localparam logic [7:0] REC_FN_CH0 = 8'h80;
  localparam logic [7:0] REC_FN_CH1 = 8'h81;
  localparam logic [7:0] PARAM_WB_OFFSET = 8'h01;
  localparam logic [7:0] PARAM_FN_OFFSET = 8'h00;
  localparam logic [15:0] REC_DIAG_FULL = 16'h0001;
  localparam logic [15:0] REC_DIAG_SHORT = 16'h0000;
  localparam logic [15:0] IDX_DIAG_FULL = 16'h2f01;
  localparam logic [15:0] IDX_DIAG_SHORT = 16'h2f00;
  localparam logic [15:0] IDX_ECAT_DIAG = 16'h5005;
  localparam logic [15:0] SUB_FIRST = 16'h0002;
  localparam logic [15:0] SUB_RSVD_LAST = 16'h0011;
  localparam logic [15:0] SUB_STAMP = 16'h0013;
  localparam logic [1:0] ACC_RECORD = 2'h0;
  localparam logic [1:0] ACC_CANOPEN = 2'h1;
  localparam logic [1:0] ACC_ETHERCAT = 2'h3;

  // ****************************************************************
  // Diagnostic record layout
  // ****************************************************************
  localparam logic [4:0] DIAG_SHORT_LEN = 5'h04;
  localparam logic [4:0] DIAG_FULL_LEN = 5'h14;
  localparam logic [4:0] BYTE_KIND = 5'h04;
  localparam logic [4:0] BYTE_STAMP = 5'h10;
  localparam logic [4:0] STAMP_LEN = 5'h04;
  localparam logic [7:0] MODULE_CLASS_INFO = 8'h15;
  localparam logic [7:0] CHANNEL_KIND = 8'h73;
  localparam logic [7:0] BITS_PER_CHANNEL = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT = 8'h02;
  localparam int SUM_MODULE_FAIL = 0;
  localparam int SUM_INTERNAL = 1;
  localparam int SUM_EXTERNAL = 2;
  localparam int SUM_CHANNEL = 3;
  localparam int SUM_AUX_MISSING = 4;
  localparam int SUM_PARAM = 7;
  localparam int DETAIL_PARAM = 0;
  localparam int DETAIL_WIRE = 4;
  localparam int INTFLAG_COMM = 4;

  // ****************************************************************
  // Scaling in microamps and timing
  // ****************************************************************
  localparam int NOM_WIDE = 27648;
  localparam int NOM_NARROW = 16384;
  localparam int OVER_WIDE = 32511;
  localparam int OVER_NARROW = 20480;
  localparam int UNDER_WIDE = -6912;
  localparam int UNDER_NARROW = -4096;
  localparam int FULL_SCALE_UA = 20000;
  localparam int SPAN_UA = 16000;
  localparam int LIVE_ZERO_UA = 4000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam logic [6:0] TICK_CYCLES = 7'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  localparam logic [31:0] TICKER_RESET = 32'h00000000;

endpackage

// File: testbench/head_station_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Head station: parameter writes and diagnostic reads
// ****************************************************************
module head_station_model (
  input wire logic sys_clk,
  output logic paramWrEn,
  output logic [7:0] paramRecordNumber,
  output logic [7:0] paramByteOffset,
  output logic [7:0] paramWrData,
  input wire logic paramWrAck,
  input wire logic paramWrReject,
  output logic diagRdEn,
  output logic [1:0] diagAccessKind,
  output logic [15:0] diagSelector,
  output logic [4:0] diagByteOffset,
  input wire logic diagRdValid,
  input wire logic [7:0] diagRdData,
  input wire logic diagRdReject
);
  initial begin
    paramWrEn = 1'b0;
    diagRdEn = 1'b0;
    {paramRecordNumber, paramByteOffset, paramWrData} = 24'h000000;
    {diagAccessKind, diagSelector, diagByteOffset} = 23'h000000;
  end
  task automatic wr(input logic [7:0] rc, input logic [7:0] of, input logic [7:0] dt,
                    output logic ack, output logic rej);
    @(negedge sys_clk);
    paramWrEn = 1'b1;
    {paramRecordNumber, paramByteOffset, paramWrData} = {rc, of, dt};
    @(negedge sys_clk);
    ack = paramWrAck;
    rej = paramWrReject;
    paramWrEn = 1'b0;
    paramWrData = ~dt;
  endtask
  task automatic rd(input logic [1:0] kind, input logic [15:0] sel, input logic [4:0] of,
                    output logic ok, output logic rej, output logic [7:0] dat);
    @(negedge sys_clk);
    diagRdEn = 1'b1;
    {diagAccessKind, diagSelector, diagByteOffset} = {kind, sel, of};
    @(negedge sys_clk);
    ok = diagRdValid;
    rej = diagRdReject;
    dat = diagRdData;
    diagRdEn = 1'b0;
    diagSelector = ~sel;
  endtask
endmodule // head_station_model

// File: testbench/tb_top.sv
`timescale 1ns/10ps
// ****************************************************************
// Bench: model-checked stimulus for the current output block
// ****************************************************************
module tb_top;
  import current_output_pkg::*;
  logic sys_clk, rst, paramWrEn, paramWrAck, paramWrReject, diagRdEn, diagRdValid, diagRdReject;
  logic [7:0] paramRecordNumber, paramByteOffset, paramWrData, diagRdData, d;
  logic [15:0] outCode0, outCode1, diagSelector;
  logic [14:0] currentUa0, currentUa1;
  logic [1:0] diagAccessKind;
  logic [4:0] diagByteOffset;
  logic channelOn0, channelOn1, wireBreakPin0, wireBreakPin1, auxSupplyMissingPin, moduleFailPin;
  logic internalCommFailPin, channelFaultLed0, channelFaultLed1, groupFaultLed, a, r;
  logic [31:0] stampExp;
  int err_total, n_tests, fn0, fn1, wbEn, cyc, c;
  int codes[11] = '{0, 27648, 32511, 32767, -6912, -6913, -1, -32768, 16384, 20480, -4096};
  int fns[4] = '{'h31, 'h41, 'h30, 'h40};
  current_output_code_and_diag DUT (.*);
  head_station_model host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= rst ? 0 : cyc + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic bit act(int fn);
    return fn == 'h30 || fn == 'h31 || fn == 'h40 || fn == 'h41;
  endfunction
  function automatic int ua(int fn, int v);
    int den, lo, hi;
    if (!act(fn)) return 0;
    den = fn < 'h40 ? NOM_WIDE : NOM_NARROW;
    hi = fn < 'h40 ? OVER_WIDE : OVER_NARROW;
    lo = fn[0] ? 0 : (fn < 'h40 ? UNDER_WIDE : UNDER_NARROW);
    v = v < lo ? lo : (v > hi ? hi : v);
    return fn[0] ? v * FULL_SCALE_UA / den : LIVE_ZERO_UA + v * SPAN_UA / den;
  endfunction
  function automatic logic [7:0] rec(int i);
    logic [7:0] b[20];
    logic p0, p1, ext;
    p0 = !act(fn0) && fn0 != 'hff;
    p1 = !act(fn1) && fn1 != 'hff;
    b = '{default: 8'h00};
    b[8] = {3'h0, wbEn[0] && act(fn0) && wireBreakPin0, 3'h0, p0};
    b[9] = {3'h0, wbEn[1] && act(fn1) && wireBreakPin1, 3'h0, p1};
    b[7] = {6'h00, b[9] != 0, b[8] != 0};
    b[3] = {3'h0, internalCommFailPin, 4'h0};
    ext = b[8][4] | b[9][4] | auxSupplyMissingPin;
    b[0] = {p0 | p1, 2'h0, auxSupplyMissingPin, b[7] != 0, ext, internalCommFailPin, moduleFailPin};
    {b[1], b[4], b[5], b[6]} = {8'h15, 8'h73, 8'h08, 8'h02};
    {b[16], b[17], b[18], b[19]} = stampExp;
    return b[i];
  endfunction
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic diag_all();
    logic [15:0] sel[4] = '{REC_DIAG_FULL, REC_DIAG_SHORT, IDX_DIAG_FULL, IDX_DIAG_SHORT};
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 21; i++) begin
        host.rd(k < 2 ? ACC_RECORD : ACC_CANOPEN, sel[k], 5'(i), a, r, d);
        chk({a, r, d}, i < (k[0] ? 4 : 20) ? {2'b10, rec(i)} : 10'h100);
      end
    end
    for (int i = 0; i < 22; i++) begin
      c = i < 16 ? i + 2 : (i < 20 ? 'h13 : 'h12);
      host.rd(i < 21 ? ACC_ETHERCAT : 2'h2, 16'(c), i < 16 ? 5'h00 : 5'(i - 16), a, r, d);
      chk({a, r, d}, i < 20 ? {2'b10, rec(i)} : 10'h100);
    end
  endtask
  // Events are placed mid-microsecond so the expected stamp is exact
  task automatic align();
    for (int n = 0; n < 101 && cyc % 100 != 45; n++) @(negedge sys_clk);
    stampExp = 32'(cyc / 100);
    if (cyc % 100 != 45) begin
      err_total++;
      results();
    end
  endtask
  task automatic put(input logic [7:0] rc, input logic [7:0] of, input logic [7:0] dt, input bit ok);
    host.wr(rc, of, dt, a, r);
    chk({a, r}, ok ? 2'b10 : 2'b01);
    if (ok && rc == REC_FN_CH0) fn0 = dt;
    if (ok && rc == REC_FN_CH1) fn1 = dt;
    if (ok && rc == REC_PARAM_BASIC) wbEn = dt & 8'h03;
  endtask
  initial begin
    rst = 1'b1;
    {outCode0, outCode1} = 32'h00000000;
    {wireBreakPin0, wireBreakPin1, auxSupplyMissingPin, moduleFailPin, internalCommFailPin} = 5'h00;
    err_total = 0;
    n_tests = 0;
    fn0 = 'h31;
    fn1 = 'h31;
    wbEn = 0;
    stampExp = 32'h00000000;
    c = $urandom(55119);
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    diag_all();
    for (int f = 0; f < 4; f++) begin
      put(REC_FN_CH0, PARAM_FN_OFFSET, 8'(fns[f]), 1'b1);
      put(REC_FN_CH1, PARAM_FN_OFFSET, 8'(fns[3 - f]), 1'b1);
      for (int j = 0; j < 40; j++) begin
        @(negedge sys_clk);
        outCode0 = j < 11 ? 16'(codes[j]) : 16'($urandom);
        outCode1 = j < 11 ? 16'(codes[10 - j]) : 16'($urandom);
        repeat (2) @(negedge sys_clk);
        chk(currentUa0, ua(fn0, $signed(outCode0)));
        chk(currentUa1, ua(fn1, $signed(outCode1)));
        chk({channelOn0, channelOn1}, 2'b11);
      end
    end
    align();
    put(REC_FN_CH1, PARAM_FN_OFFSET, 8'h55, 1'b1);
    put(REC_FN_CH0, PARAM_FN_OFFSET, FN_OFF, 1'b1);
    repeat (2) @(negedge sys_clk);
    chk({channelOn0, channelOn1, currentUa0, currentUa1}, 32'h0);
    chk({channelFaultLed0, channelFaultLed1, groupFaultLed}, 3'b011);
    diag_all();
    align();
    put(REC_FN_CH1, PARAM_FN_OFFSET, 8'h31, 1'b1);
    put(REC_FN_CH0, PARAM_FN_OFFSET, 8'h30, 1'b1);
    put(REC_PARAM_BASIC, PARAM_WB_OFFSET, 8'hfd, 1'b1);
    align();
    {wireBreakPin0, wireBreakPin1} = 2'b11;
    repeat (6) @(negedge sys_clk);
    chk({channelFaultLed0, channelFaultLed1}, 2'b10);
    diag_all();
    align();
    {auxSupplyMissingPin, moduleFailPin, internalCommFailPin} = 3'b111;
    repeat (6) @(negedge sys_clk);
    diag_all();
    align();
    {wireBreakPin0, wireBreakPin1, auxSupplyMissingPin, moduleFailPin, internalCommFailPin} = 5'h00;
    repeat (6) @(negedge sys_clk);
    diag_all();
    put(REC_PARAM_BASIC, PARAM_FN_OFFSET, 8'h01, 1'b0);
    put(8'h55, 8'h00, 8'h30, 1'b0);
    results();
  end
endmodule // tb_top
